/* logic/gpfgh_defs.svh */
// constants for the port f/g/h pin block: addresses, reset values, codes, widths
// assumes a single AHB-Lite slave select decoded outside; full byte addresses compared
`ifndef GPFGH_DEFS_SVH
`define GPFGH_DEFS_SVH

`define GPFGH_F_PINS      8
`define GPFGH_G_PINS      16
`define GPFGH_H_PINS      11
`define GPFGH_LINES       24
`define GPFGH_G_LINE_BASE 8

`define GPFGH_F_CON_ADDR  32'h5600_0050
`define GPFGH_F_DAT_ADDR  32'h5600_0054
`define GPFGH_F_UP_ADDR   32'h5600_0058
`define GPFGH_F_RSV_ADDR  32'h5600_005C
`define GPFGH_G_CON_ADDR  32'h5600_0060
`define GPFGH_G_DAT_ADDR  32'h5600_0064
`define GPFGH_G_UP_ADDR   32'h5600_0068
`define GPFGH_H_CON_ADDR  32'h5600_0070
`define GPFGH_H_DAT_ADDR  32'h5600_0074
`define GPFGH_H_UP_ADDR   32'h5600_0078
`define GPFGH_STAT_ADDR   32'h5600_00A0
`define GPFGH_MASK_ADDR   32'h5600_00A4

`define GPFGH_CON_RST     32'h0000_0000
`define GPFGH_DAT_RST     16'h0000
`define GPFGH_F_UP_RST    8'h00
`define GPFGH_G_UP_RST    16'hf800
`define GPFGH_H_UP_RST    11'h000

`define GPFGH_G_FN3_MASK  16'hf8fc
`define GPFGH_H_FN3_MASK  11'h0c0

`endif

/* logic/gpfgh_pkg.sv */
// types shared by the port f/g/h pin block
// assumes gpfgh_defs.svh is on the include path
`default_nettype none
`include "gpfgh_defs.svh"
package gpfgh_pkg;

	typedef enum logic [1:0]
	{
		GPFGH_MODE_IN  = 2'h0,
		GPFGH_MODE_OUT = 2'h1,
		GPFGH_MODE_FN2 = 2'h2,
		GPFGH_MODE_FN3 = 2'h3
	} gpfgh_mode_t;

	typedef struct packed
	{
		logic [2*`GPFGH_F_PINS-1:0] pf_con;
		logic [`GPFGH_F_PINS-1:0]   pf_dat;
		logic [`GPFGH_F_PINS-1:0]   pf_up;
		logic [2*`GPFGH_G_PINS-1:0] pg_con;
		logic [`GPFGH_G_PINS-1:0]   pg_dat;
		logic [`GPFGH_G_PINS-1:0]   pg_up;
		logic [2*`GPFGH_H_PINS-1:0] ph_con;
		logic [`GPFGH_H_PINS-1:0]   ph_dat;
		logic [`GPFGH_H_PINS-1:0]   ph_up;
		logic [`GPFGH_F_PINS-1:0]   pf_pin;
		logic [`GPFGH_G_PINS-1:0]   pg_pin;
		logic [`GPFGH_H_PINS-1:0]   ph_pin;
		logic [`GPFGH_LINES-1:0]    line;
		logic [`GPFGH_LINES-1:0]    stat;
		logic [`GPFGH_LINES-1:0]    mask;
		logic                       wr_pend;
		logic [31:0]                addr;
		logic [31:0]                rdata;
	} gpfgh_state_t;

	function automatic gpfgh_mode_t gpfgh_field(input logic [31:0] con, input int i);
		gpfgh_field = gpfgh_mode_t'(con[2*i +: 2]);
	endfunction : gpfgh_field

endpackage : gpfgh_pkg
`default_nettype wire

/* logic/gpfgh_pin_cell.sv */
// pin steering for one port: mode field per pin picks driver and irq routing; pull-up from its own bit
// assumes registered configuration and data from the owning top
`default_nettype none
module gpfgh_pin_cell
	import gpfgh_pkg::*;
#(
	parameter int           N           = 8,
	parameter bit           FN2_IS_IRQ  = 1'b1,
	parameter logic [N-1:0] FN3_MASK    = '0
)
(
	input  wire logic [2*N-1:0] con,
	input  wire logic [N-1:0]   dat,
	input  wire logic [N-1:0]   up_off,
	input  wire logic [N-1:0]   fn2_out,
	input  wire logic [N-1:0]   fn2_oe,
	input  wire logic [N-1:0]   fn3_out,
	input  wire logic [N-1:0]   fn3_oe,
	output logic      [N-1:0]   pin_out,
	output logic      [N-1:0]   pin_oe,
	output logic      [N-1:0]   pullup_en,
	output logic      [N-1:0]   irq_sel
);

	always_comb
	begin
		pin_out   = '0;
		pin_oe    = '0;
		irq_sel   = '0;
		pullup_en = ~up_off;
		for (int i = 0; i < N; i++)
		begin
			unique case (gpfgh_field(32'(con), i))
				GPFGH_MODE_IN:
				begin
					pin_oe[i] = 1'b0;
				end
				GPFGH_MODE_OUT:
				begin
					pin_out[i] = dat[i];
					pin_oe[i]  = 1'b1;
				end
				GPFGH_MODE_FN2:
				begin
					if (FN2_IS_IRQ)
						irq_sel[i] = 1'b1;
					else
					begin
						pin_out[i] = fn2_out[i];
						pin_oe[i]  = fn2_oe[i];
					end
				end
				GPFGH_MODE_FN3:
				begin
					// reserved codes fall back to a plain input, driver off
					if (FN3_MASK[i])
					begin
						pin_out[i] = fn3_out[i];
						pin_oe[i]  = fn3_oe[i];
					end
				end
			endcase
		end
	end

endmodule : gpfgh_pin_cell
`default_nettype wire

/* logic/gpfgh_top.sv */
// port f/g/h general purpose pin block with AHB-Lite register slave and edge interrupts
// assumes pin inputs synchronous to REF_CLK and zero-wait single word transfers
//
// Operation
// - eight-pin port pins used for wake-up must be in external interrupt mode.
// - eight-pin config: 2-bit field per pin; 00 in, 01 out, 10 irq, 11 reserved.
// - sixteen-pin config resets 0; 10 irq lines 8-23; 11 per-pin peripheral; the code drives it on pins 2-7 and 11-15 only, the rest stay off.
// - data read returns sampled pin level for input pins.
// - output pins drive the data register bit, updated on write.
// - data read of peripheral or interrupt pins is unspecified.
// - pull-up bit 0 keeps pull-up, 1 disconnects it.
// - eight-pin pull-up register resets to 0.
// - sixteen-pin pull-up register resets to f800, pins 11-15 off.
// - registers decode at fixed addresses; the fourth word of each port reserved.
// - data registers have no defined reset value.
// - third port config, data, pull-up at fixed addresses; config and pull-up reset 0.
// - third port eleven pins; 10 serial functions, 11 flow control on 6 and 7.
`default_nettype none
`include "gpfgh_defs.svh"
module gpfgh_top
	import gpfgh_pkg::*;
(
	input  wire logic                     REF_CLK,
	input  wire logic                     RST,
	input  wire logic                     HSEL,
	input  wire logic [31:0]              HADDR,
	input  wire logic [1:0]               HTRANS,
	input  wire logic                     HWRITE,
	input  wire logic [2:0]               HSIZE,
	input  wire logic [31:0]              HWDATA,
	input  wire logic                     HREADY,
	output logic                          HREADYOUT,
	output logic                          HRESP,
	output logic      [31:0]              HRDATA,
	input  wire logic [`GPFGH_F_PINS-1:0] PF_IN,
	output logic      [`GPFGH_F_PINS-1:0] PF_OUT,
	output logic      [`GPFGH_F_PINS-1:0] PF_OE,
	output logic      [`GPFGH_F_PINS-1:0] PF_PULLUP_EN,
	input  wire logic [`GPFGH_G_PINS-1:0] PG_IN,
	output logic      [`GPFGH_G_PINS-1:0] PG_OUT,
	output logic      [`GPFGH_G_PINS-1:0] PG_OE,
	output logic      [`GPFGH_G_PINS-1:0] PG_PULLUP_EN,
	input  wire logic [`GPFGH_G_PINS-1:0] PG_FN3_OUT,
	input  wire logic [`GPFGH_G_PINS-1:0] PG_FN3_OE,
	input  wire logic [`GPFGH_H_PINS-1:0] PH_IN,
	output logic      [`GPFGH_H_PINS-1:0] PH_OUT,
	output logic      [`GPFGH_H_PINS-1:0] PH_OE,
	output logic      [`GPFGH_H_PINS-1:0] PH_PULLUP_EN,
	input  wire logic [`GPFGH_H_PINS-1:0] PH_FN2_OUT,
	input  wire logic [`GPFGH_H_PINS-1:0] PH_FN2_OE,
	input  wire logic [`GPFGH_H_PINS-1:0] PH_FN3_OUT,
	input  wire logic [`GPFGH_H_PINS-1:0] PH_FN3_OE,
	output logic      [`GPFGH_LINES-1:0]  EXT_IRQ_LINE,
	output logic                          IRQ
);

	localparam int FP = `GPFGH_F_PINS;
	localparam int GP = `GPFGH_G_PINS;
	localparam int HP = `GPFGH_H_PINS;

	gpfgh_state_t          s_r;
	gpfgh_state_t          s_nxt;
	logic [FP-1:0]         f_irq_sel;
	logic [GP-1:0]         g_irq_sel;
	logic [`GPFGH_LINES-1:0] line_now;
	logic                  addr_ok;

	// readback: output pins show the data bit, all others the sampled pin
	function automatic logic [15:0] port_rb(input logic [31:0] con,
		input logic [15:0] dat, input logic [15:0] pin);
		port_rb = '0;
		for (int i = 0; i < 16; i++)
			port_rb[i] = (gpfgh_field(con, i) == GPFGH_MODE_OUT) ? dat[i] : pin[i];
	endfunction : port_rb

	gpfgh_pin_cell #(
		.N          (FP),
		.FN2_IS_IRQ (1'b1),
		.FN3_MASK   ('0)
	) u_port_f (
		.con       (s_r.pf_con),
		.dat       (s_r.pf_dat),
		.up_off    (s_r.pf_up),
		.fn2_out   ('0),
		.fn2_oe    ('0),
		.fn3_out   ('0),
		.fn3_oe    ('0),
		.pin_out   (PF_OUT),
		.pin_oe    (PF_OE),
		.pullup_en (PF_PULLUP_EN),
		.irq_sel   (f_irq_sel)
	);

	gpfgh_pin_cell #(
		.N          (GP),
		.FN2_IS_IRQ (1'b1),
		.FN3_MASK   (`GPFGH_G_FN3_MASK)
	) u_port_g (
		.con       (s_r.pg_con),
		.dat       (s_r.pg_dat),
		.up_off    (s_r.pg_up),
		.fn2_out   ('0),
		.fn2_oe    ('0),
		.fn3_out   (PG_FN3_OUT),
		.fn3_oe    (PG_FN3_OE),
		.pin_out   (PG_OUT),
		.pin_oe    (PG_OE),
		.pullup_en (PG_PULLUP_EN),
		.irq_sel   (g_irq_sel)
	);

	gpfgh_pin_cell #(
		.N          (HP),
		.FN2_IS_IRQ (1'b0),
		.FN3_MASK   (`GPFGH_H_FN3_MASK)
	) u_port_h (
		.con       (s_r.ph_con),
		.dat       (s_r.ph_dat),
		.up_off    (s_r.ph_up),
		.fn2_out   (PH_FN2_OUT),
		.fn2_oe    (PH_FN2_OE),
		.fn3_out   (PH_FN3_OUT),
		.fn3_oe    (PH_FN3_OE),
		.pin_out   (PH_OUT),
		.pin_oe    (PH_OE),
		.pullup_en (PH_PULLUP_EN),
		.irq_sel   ()
	);

	// the interrupt lines only pass a pin that is steered to them
	assign line_now = {s_r.pg_pin & g_irq_sel, s_r.pf_pin & f_irq_sel};
	assign addr_ok  = HSEL && HTRANS[1] && HREADY;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.pf_pin = PF_IN;
		s_nxt.pg_pin = PG_IN;
		s_nxt.ph_pin = PH_IN;
		if (s_r.wr_pend)
		begin
			unique case (s_r.addr)
				`GPFGH_F_CON_ADDR: s_nxt.pf_con = HWDATA[2*FP-1:0];
				`GPFGH_F_DAT_ADDR: s_nxt.pf_dat = HWDATA[FP-1:0];
				`GPFGH_F_UP_ADDR:  s_nxt.pf_up  = HWDATA[FP-1:0];
				`GPFGH_G_CON_ADDR: s_nxt.pg_con = HWDATA[2*GP-1:0];
				`GPFGH_G_DAT_ADDR: s_nxt.pg_dat = HWDATA[GP-1:0];
				`GPFGH_G_UP_ADDR:  s_nxt.pg_up  = HWDATA[GP-1:0];
				`GPFGH_H_CON_ADDR: s_nxt.ph_con = HWDATA[2*HP-1:0];
				`GPFGH_H_DAT_ADDR: s_nxt.ph_dat = HWDATA[HP-1:0];
				`GPFGH_H_UP_ADDR:  s_nxt.ph_up  = HWDATA[HP-1:0];
				`GPFGH_STAT_ADDR:  s_nxt.stat   = s_r.stat & ~HWDATA[`GPFGH_LINES-1:0];
				`GPFGH_MASK_ADDR:  s_nxt.mask   = HWDATA[`GPFGH_LINES-1:0];
				default:           s_nxt.stat   = s_r.stat;
			endcase
		end
		// rising edge on a routed line; a new event beats a same-cycle clear
		s_nxt.line = line_now;
		s_nxt.stat = s_nxt.stat | (line_now & ~s_r.line);
		s_nxt.wr_pend = addr_ok && HWRITE;
		s_nxt.addr    = HADDR;
		// read data taken from the next state so a write just before is seen
		s_nxt.rdata = '0;
		if (addr_ok && !HWRITE)
		begin
			unique case (HADDR)
				`GPFGH_F_CON_ADDR: s_nxt.rdata = 32'(s_nxt.pf_con);
				`GPFGH_F_DAT_ADDR: s_nxt.rdata = 32'(port_rb(32'(s_nxt.pf_con),
					16'(s_nxt.pf_dat), 16'(s_nxt.pf_pin)) & 16'h00ff);
				`GPFGH_F_UP_ADDR:  s_nxt.rdata = 32'(s_nxt.pf_up);
				`GPFGH_G_CON_ADDR: s_nxt.rdata = s_nxt.pg_con;
				`GPFGH_G_DAT_ADDR: s_nxt.rdata = 32'(port_rb(s_nxt.pg_con,
					s_nxt.pg_dat, s_nxt.pg_pin));
				`GPFGH_G_UP_ADDR:  s_nxt.rdata = 32'(s_nxt.pg_up);
				`GPFGH_H_CON_ADDR: s_nxt.rdata = 32'(s_nxt.ph_con);
				`GPFGH_H_DAT_ADDR: s_nxt.rdata = 32'(port_rb(32'(s_nxt.ph_con),
					16'(s_nxt.ph_dat), 16'(s_nxt.ph_pin)) & 16'h07ff);
				`GPFGH_H_UP_ADDR:  s_nxt.rdata = 32'(s_nxt.ph_up);
				`GPFGH_STAT_ADDR:  s_nxt.rdata = 32'(s_nxt.stat);
				`GPFGH_MASK_ADDR:  s_nxt.rdata = 32'(s_nxt.mask);
				default:           s_nxt.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			s_r        <= '0;
			s_r.pf_con <= 16'(`GPFGH_CON_RST);
			s_r.pg_con <= `GPFGH_CON_RST;
			s_r.ph_con <= 22'(`GPFGH_CON_RST);
			s_r.pf_up  <= `GPFGH_F_UP_RST;
			s_r.pg_up  <= `GPFGH_G_UP_RST;
			s_r.ph_up  <= `GPFGH_H_UP_RST;
			// data words carry no promised value; zero only keeps sims clean
			s_r.pf_dat <= 8'(`GPFGH_DAT_RST);
			s_r.pg_dat <= `GPFGH_DAT_RST;
			s_r.ph_dat <= 11'(`GPFGH_DAT_RST);
		end
		else
			s_r <= s_nxt;
	end

	// zero wait states: every transfer is answered in its first data cycle
	assign HREADYOUT    = 1'b1;
	assign HRESP        = 1'b0;
	assign HRDATA       = s_r.rdata;
	assign EXT_IRQ_LINE = s_r.line;
	assign IRQ          = |(s_r.stat & s_r.mask);

	sequence wr_addr_s(logic [31:0] a);
		addr_ok && HWRITE && (HADDR == a);
	endsequence

	sequence rd_addr_s(logic [31:0] a);
		addr_ok && !HWRITE && (HADDR == a);
	endsequence

	reset_values_a: assert property (@(posedge REF_CLK)
		$past(RST) && !RST |-> s_r.pg_up == `GPFGH_G_UP_RST && s_r.pf_up == `GPFGH_F_UP_RST
		&& s_r.pg_con == `GPFGH_CON_RST && s_r.ph_up == `GPFGH_H_UP_RST)
		else $error("pull-up or config reset value wrong");

	f_data_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
		wr_addr_s(`GPFGH_F_DAT_ADDR) ##1 !addr_ok |=>
		s_r.pf_dat == $past(HWDATA[7:0]))
		else $error("eight-pin data write not stored");

	f_out_drive_a: assert property (@(posedge REF_CLK) disable iff (RST)
		gpfgh_field(32'(s_r.pf_con), 3) == GPFGH_MODE_OUT |-> PF_OE[3] && PF_OUT[3] == s_r.pf_dat[3])
		else $error("output pin not driven from data");

	f_in_read_a: assert property (@(posedge REF_CLK) disable iff (RST)
		rd_addr_s(`GPFGH_F_DAT_ADDR) && !s_r.wr_pend && s_r.pf_con == '0 |=>
		HRDATA == 32'($past(PF_IN)))
		else $error("input pin level not returned");

	g_pullup_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
		wr_addr_s(`GPFGH_G_UP_ADDR) ##1 !addr_ok |=> PG_PULLUP_EN == ~$past(HWDATA[15:0]))
		else $error("pull-up enable not inverse of written bit");

	reserved_code_a: assert property (@(posedge REF_CLK) disable iff (RST)
		gpfgh_field(s_r.pg_con, 0) == GPFGH_MODE_FN3 |-> !PG_OE[0])
		else $error("reserved code drives pin");

	g_alt_route_a: assert property (@(posedge REF_CLK) disable iff (RST)
		gpfgh_field(s_r.pg_con, 11) == GPFGH_MODE_FN3 |-> PG_OE[11] == PG_FN3_OE[11]
		&& PG_OUT[11] == PG_FN3_OUT[11])
		else $error("timer clock alternate not routed");

	h_flow_route_a: assert property (@(posedge REF_CLK) disable iff (RST)
		gpfgh_field(32'(s_r.ph_con), 6) == GPFGH_MODE_FN3 |-> PH_OE[6] == PH_FN3_OE[6])
		else $error("flow control alternate not routed");

	reserved_word_a: assert property (@(posedge REF_CLK) disable iff (RST)
		wr_addr_s(`GPFGH_F_RSV_ADDR) ##1 !addr_ok |=> $stable(s_r.pf_con) && $stable(s_r.pf_up))
		else $error("reserved word write changed a register");

	wake_line_a: assert property (@(posedge REF_CLK) disable iff (RST)
		gpfgh_field(32'(s_r.pf_con), 0) == GPFGH_MODE_FN2 && s_r.pf_pin[0] |=> EXT_IRQ_LINE[0])
		else $error("wake-up line not raised");

	irq_event_a: assert property (@(posedge REF_CLK) disable iff (RST)
		!s_r.line[2] && line_now[2] && s_r.mask[2] |=> s_r.stat[2] && IRQ)
		else $error("line edge did not raise interrupt");

	// a write lands at the edge that ends its data phase, so checks look one edge later
	sequence wr_land_s(logic [31:0] a);
		wr_addr_s(a) ##1 !addr_ok;
	endsequence

	f_pullup_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
		wr_land_s(`GPFGH_F_UP_ADDR) |=> PF_PULLUP_EN == ~$past(HWDATA[FP-1:0]))
		else $error("eight-pin pull-up enable not inverse of written bit");

	h_pullup_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
		wr_land_s(`GPFGH_H_UP_ADDR) |=> PH_PULLUP_EN == ~$past(HWDATA[HP-1:0]))
		else $error("third port pull-up enable not inverse of written bit");

	g_con_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
		wr_land_s(`GPFGH_G_CON_ADDR) |=> s_r.pg_con == $past(HWDATA))
		else $error("sixteen-pin config write not stored as written");

	h_con_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
		wr_land_s(`GPFGH_H_CON_ADDR) |=> s_r.ph_con == $past(HWDATA[2*HP-1:0]))
		else $error("third port config write not stored as written");

	g_data_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
		wr_land_s(`GPFGH_G_DAT_ADDR) |=> s_r.pg_dat == $past(HWDATA[GP-1:0]))
		else $error("sixteen-pin data write not stored");

	g_out_drive_a: assert property (@(posedge REF_CLK) disable iff (RST)
		gpfgh_field(s_r.pg_con, 9) == GPFGH_MODE_OUT |-> PG_OE[9] && PG_OUT[9] == s_r.pg_dat[9])
		else $error("sixteen-pin output not driven from data");

	h_out_drive_a: assert property (@(posedge REF_CLK) disable iff (RST)
		gpfgh_field(32'(s_r.ph_con), 10) == GPFGH_MODE_OUT |->
		PH_OE[10] && PH_OUT[10] == s_r.ph_dat[10])
		else $error("third port output not driven from data");

	f_input_off_a: assert property (@(posedge REF_CLK) disable iff (RST)
		gpfgh_field(32'(s_r.pf_con), 5) == GPFGH_MODE_IN |-> !PF_OE[5])
		else $error("input pin driven");

	f_reserved_a: assert property (@(posedge REF_CLK) disable iff (RST)
		gpfgh_field(32'(s_r.pf_con), 7) == GPFGH_MODE_FN3 |-> !PF_OE[7])
		else $error("eight-pin reserved code drives pin");

	h_reserved_a: assert property (@(posedge REF_CLK) disable iff (RST)
		gpfgh_field(32'(s_r.ph_con), 0) == GPFGH_MODE_FN3 |-> !PH_OE[0])
		else $error("third port reserved code drives pin");

	h_serial_route_a: assert property (@(posedge REF_CLK) disable iff (RST)
		gpfgh_field(32'(s_r.ph_con), 2) == GPFGH_MODE_FN2 |->
		PH_OE[2] == PH_FN2_OE[2] && PH_OUT[2] == PH_FN2_OUT[2])
		else $error("serial function not routed");

	line_blocked_a: assert property (@(posedge REF_CLK) disable iff (RST)
		gpfgh_field(32'(s_r.pf_con), 4) != GPFGH_MODE_FN2 |=> !EXT_IRQ_LINE[4])
		else $error("interrupt line raised outside interrupt mode");

	g_wake_line_a: assert property (@(posedge REF_CLK) disable iff (RST)
		gpfgh_field(s_r.pg_con, 15) == GPFGH_MODE_FN2 && s_r.pg_pin[15] |=>
		EXT_IRQ_LINE[23])
		else $error("sixteen-pin interrupt line not raised");

	stat_clear_a: assert property (@(posedge REF_CLK) disable iff (RST)
		wr_addr_s(`GPFGH_STAT_ADDR) ##1 (!addr_ok && HWDATA[5]
		&& !(line_now[5] && !s_r.line[5])) |=> !s_r.stat[5])
		else $error("status bit not cleared by writing one");

	g_in_read_a: assert property (@(posedge REF_CLK) disable iff (RST)
		rd_addr_s(`GPFGH_G_DAT_ADDR) && !s_r.wr_pend && s_r.pg_con == '0 |=>
		HRDATA == 32'($past(PG_IN)))
		else $error("sixteen-pin input level not returned");

	rdata_idle_a: assert property (@(posedge REF_CLK) disable iff (RST)
		!(addr_ok && !HWRITE) |=> HRDATA == '0)
		else $error("read data not zero outside a read data phase");

endmodule : gpfgh_top
`default_nettype wire

/* dv/gpfgh_pin_model.sv */
// board and pad model for one port: resolves each pad from driver, board and pull-up
// assumes the bench picks board drive; a pad held by nobody toggles every cycle
`default_nettype none
module gpfgh_pin_model
#(
	parameter int N = 8
)
(
	input  wire logic         clk,
	input  wire logic [N-1:0] out,
	input  wire logic [N-1:0] oe,
	input  wire logic [N-1:0] pu_en,
	input  wire logic [N-1:0] ext,
	input  wire logic [N-1:0] ext_en,
	output var logic  [N-1:0] lvl
);
	timeunit 1ns;
	timeprecision 1ps;

	initial lvl = '0;

	// pad driver wins over the board; floating pads never hold a stale level
	always @(posedge clk)
		lvl <= (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & pu_en)
			| (~oe & ~ext_en & ~pu_en & ~lvl);
endmodule : gpfgh_pin_model
`default_nettype wire

/* dv/gpfgh_top_test.sv */
// self-checking bench for the port f/g/h pin block over AHB-Lite
// assumes gpfgh_defs.svh on the include path and the pad model beside it
`default_nettype none
`include "gpfgh_defs.svh"
module gpfgh_top_test
	import gpfgh_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        ref_clk = 1'b0;
	logic        rst     = 1'b1;
	logic        hsel    = 1'b0;
	logic        hwrite  = 1'b0;
	logic [1:0]  htrans  = 2'h0;
	logic [2:0]  hsize   = 3'h2;
	logic [31:0] haddr   = '0;
	logic [31:0] hwdata  = '0;
	logic [31:0] seed    = 32'h01d7_16ce;
	logic [31:0] r, q;
	logic [7:0]  fx = '0, fe = '1;
	logic [15:0] gx = '0, ge = '1, pg_f3o = '0, pg_f3e = '0;
	logic [10:0] hx = '0, he = '1, ph_f2o = '0, ph_f2e = '0, ph_f3o = '0, ph_f3e = '0;
	wire logic        hready, hresp;
	wire logic [31:0] hrdata;
	wire logic [7:0]  pf_o, pf_oe, pf_pu, pf_i;
	wire logic [15:0] pg_o, pg_oe, pg_pu, pg_i;
	wire logic [10:0] ph_o, ph_oe, ph_pu, ph_i;
	wire logic [23:0] irq_ln;
	wire logic        irq;
	int               err_count = 0;
	int               compares  = 0;
	int               p;
	logic [31:0]      ra [6] = '{`GPFGH_F_CON_ADDR, `GPFGH_F_UP_ADDR, `GPFGH_G_CON_ADDR,
		`GPFGH_G_UP_ADDR, `GPFGH_H_CON_ADDR, `GPFGH_H_UP_ADDR};
	logic [31:0]      rm [6] = '{32'h0000_ffff, 32'h0000_00ff, 32'hffff_ffff,
		32'h0000_ffff, 32'h003f_ffff, 32'h0000_07ff};

	always #2.5 ref_clk = ~ref_clk;

	gpfgh_top u_dut (.REF_CLK(ref_clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hready), .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata),
		.PF_IN(pf_i), .PF_OUT(pf_o), .PF_OE(pf_oe), .PF_PULLUP_EN(pf_pu),
		.PG_IN(pg_i), .PG_OUT(pg_o), .PG_OE(pg_oe), .PG_PULLUP_EN(pg_pu),
		.PG_FN3_OUT(pg_f3o), .PG_FN3_OE(pg_f3e), .PH_IN(ph_i), .PH_OUT(ph_o),
		.PH_OE(ph_oe), .PH_PULLUP_EN(ph_pu), .PH_FN2_OUT(ph_f2o), .PH_FN2_OE(ph_f2e),
		.PH_FN3_OUT(ph_f3o), .PH_FN3_OE(ph_f3e), .EXT_IRQ_LINE(irq_ln), .IRQ(irq));
	gpfgh_pin_model #(.N(8)) u_pf (.clk(ref_clk), .out(pf_o), .oe(pf_oe), .pu_en(pf_pu),
		.ext(fx), .ext_en(fe), .lvl(pf_i));
	gpfgh_pin_model #(.N(16)) u_pg (.clk(ref_clk), .out(pg_o), .oe(pg_oe), .pu_en(pg_pu),
		.ext(gx), .ext_en(ge), .lvl(pg_i));
	gpfgh_pin_model #(.N(11)) u_ph (.clk(ref_clk), .out(ph_o), .oe(ph_oe), .pu_en(ph_pu),
		.ext(hx), .ext_en(he), .lvl(ph_i));

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd

	// input pins read the pad, output pins read back the data bit
	function automatic logic [31:0] exp_dat(input logic [31:0] con, input logic [31:0] dat,
		input logic [31:0] pin, input int n);
		logic [31:0] e;
		e = '0;
		for (int i = 0; i < n; i++)
			e[i] = (con[2*i +: 2] == 2'h1) ? dat[i] : pin[i];
		return e;
	endfunction : exp_dat

	task automatic test_done;
		$display("counts: errors=%0d compares=%0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic rdy;
		int n = 0;
		@(posedge ref_clk);
		while (hready !== 1'b1)
		begin
			n++;
			if (n > 64)
			begin
				err_count++;
				test_done;
			end
			@(posedge ref_clk);
		end
	endtask : rdy

	// one single word transfer: address phase, then data phase, data taken at its end
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		rdy;
		htrans <= 2'h0;
		if (w)
			hwdata <= d;
		rdy;
		q = hrdata;
	endtask : bus

	task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, '0);
		chk(nm, q, e);
	endtask : rdchk

	task automatic cfg(input logic [31:0] f, input logic [31:0] g, input logic [31:0] h);
		bus(1'b1, `GPFGH_F_CON_ADDR, f);
		bus(1'b1, `GPFGH_G_CON_ADDR, g);
		bus(1'b1, `GPFGH_H_CON_ADDR, h);
		repeat (4) @(posedge ref_clk);
	endtask : cfg

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		test_done;
	end

	initial
	begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rdchk("g_con", `GPFGH_G_CON_ADDR, '0);
		rdchk("h_con", `GPFGH_H_CON_ADDR, '0);
		rdchk("f_up", `GPFGH_F_UP_ADDR, '0);
		rdchk("g_up", `GPFGH_G_UP_ADDR, 32'h0000_f800);
		rdchk("h_up", `GPFGH_H_UP_ADDR, '0);
		chk("g_pu_en", {16'h0000, pg_pu}, 32'h0000_07ff);
		chk("f_oe_rst", {24'h00_0000, pf_oe}, '0);
		chk("hresp", {31'h0, hresp}, '0);
		foreach (ra[j])
		begin
			bus(1'b1, 32'h5600_005c + 32'h0000_0010 * (j % 3), rnd());
			rdchk("reserved", 32'h5600_005c + 32'h0000_0010 * (j % 3), '0);
		end
		for (int k = 0; k < 3; k++)
			foreach (ra[j])
			begin
				r = rnd();
				bus(1'b1, ra[j], r);
				rdchk("cfg_rw", ra[j], r & rm[j]);
			end
		r = rnd();
		foreach (ra[j])
			if (j % 2 == 1)
				bus(1'b1, ra[j], r);
		repeat (2) @(posedge ref_clk);
		chk("pu_en", {pf_pu, pg_pu}, {8'h00, ~r[7:0], ~r[15:0]});
		chk("h_pu_en", {21'h0, ph_pu}, {21'h0, ~r[10:0]});
		cfg('0, '0, '0);
		for (int k = 0; k < 4; k++)
		begin
			r = rnd();
			fx <= r[7:0];
			gx <= r[23:8];
			hx <= r[31:21];
			repeat (4) @(posedge ref_clk);
			rdchk("f_in", `GPFGH_F_DAT_ADDR, exp_dat('0, '0, r[7:0], 8));
			rdchk("g_in", `GPFGH_G_DAT_ADDR, exp_dat('0, '0, r[23:8], 16));
			rdchk("h_in", `GPFGH_H_DAT_ADDR, exp_dat('0, '0, r[31:21], 11));
			chk("oe_in", {pf_oe, pg_oe}, '0);
			chk("h_oe_in", {21'h0, ph_oe}, '0);
		end
		cfg(32'h0000_5555, 32'h5555_5555, 32'h0015_5555);
		r = rnd();
		bus(1'b1, `GPFGH_F_DAT_ADDR, r);
		bus(1'b1, `GPFGH_G_DAT_ADDR, r);
		bus(1'b1, `GPFGH_H_DAT_ADDR, r);
		repeat (4) @(posedge ref_clk);
		chk("out", {pf_o, pg_o}, {r[7:0], r[15:0]});
		chk("h_out", {21'h0, ph_o}, {21'h0, r[10:0]});
		chk("oe_out", {pf_oe, pg_oe}, 32'h00ff_ffff);
		chk("h_oe_out", {21'h0, ph_oe}, 32'h0000_07ff);
		rdchk("f_rb", `GPFGH_F_DAT_ADDR, exp_dat(32'h5555, r, '0, 8));
		rdchk("h_rb", `GPFGH_H_DAT_ADDR, exp_dat(32'h0015_5555, r, '0, 11));
		// reserved codes and peripheral codes share the code 11 decode
		pg_f3e <= '1;
		pg_f3o <= 16'h1000;
		ph_f3e <= '1;
		ph_f3o <= 11'h040;
		ph_f2e <= '1;
		ph_f2o <= r[26:16];
		cfg(32'h0000_ffff, 32'h0303_0000, 32'h0000_f000);
		chk("f_rsv_oe", {24'h0, pf_oe}, '0);
		chk("g_fn3", {pg_oe, pg_o}, {16'h1000, 16'h1000 | 16'h0000});
		chk("h_fn3", {ph_oe, ph_o}, {11'h0c0, 11'h040});
		rdchk("f_rsv_rb", `GPFGH_F_CON_ADDR, 32'h0000_ffff);
		cfg('0, '0, 32'h002a_aaaa);
		chk("h_fn2", {ph_oe, ph_o}, {11'h7ff, r[26:16]});
		fx <= '0;
		gx <= '0;
		cfg(32'h0000_aaaa, 32'haaaa_aaaa, '0);
		bus(1'b1, `GPFGH_STAT_ADDR, 32'h00ff_ffff);
		for (int k = 0; k < 4; k++)
		begin
			bus(1'b1, `GPFGH_MASK_ADDR, 32'h00ff_ffff);
			p = (k == 0) ? 0 : (k == 1) ? 23 : (k == 2) ? 2 : rnd() % 24;
			if (p < 8)
				fx[p] <= 1'b1;
			else
				gx[p - 8] <= 1'b1;
			repeat (4) @(posedge ref_clk);
			chk("line", {8'h00, irq_ln}, 32'h1 << p);
			chk("irq_on", {31'h0, irq}, 32'h1);
			rdchk("stat", `GPFGH_STAT_ADDR, 32'h1 << p);
			bus(1'b1, `GPFGH_MASK_ADDR, '0);
			@(posedge ref_clk);
			chk("irq_mask", {31'h0, irq}, '0);
			fx <= '0;
			gx <= '0;
			bus(1'b1, `GPFGH_STAT_ADDR, 32'h1 << p);
			repeat (4) @(posedge ref_clk);
			rdchk("stat_clr", `GPFGH_STAT_ADDR, '0);
		end
		test_done;
	end
endmodule : gpfgh_top_test
`default_nettype wire
